// file: logic/lfs_supervisor.sv
// controller side of the loop fault supervisor
`include "lfs_consts.svh"
module lfs_supervisor #(
  parameter int FW = 4,
  parameter int NA = 4,
  parameter int CYCLE_TICKS = `LFS_MS2CYC(`LFS_CYCLE_MS),
  parameter int SEC_TICKS = `LFS_MS2CYC(`LFS_SEC_MS),
  parameter int HB_TICKS = `LFS_MS2CYC(`LFS_HB_MS),
  parameter int RET_TICKS = `LFS_MS2CYC(`LFS_RET_MS)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // condition inputs, levels
  input wire logic ctrl_fault,
  input wire logic dev_offline,
  input wire logic [FW-1:0] field_fault,
  input wire logic [NA-1:0] alarm_in,
  input wire logic reset_btn,
  // annunciation
  output logic trouble_led,
  output logic loop_fault_led,
  output logic alarm_led,
  output logic trouble_relay,
  output lfs_pkg::lfs_tone_e tone,
  output logic disp_alarm,
  output logic [`LFS_CODE_W-1:0] disp_code,
  output logic disp_offline,
  // heartbeat on the signaling_line_circuit
  output logic hb_send_a,
  output logic hb_send_b,
  output logic hb_with_time,
  input wire logic hb_rx_a,
  input wire logic hb_rx_b,
  // user logic engine
  output logic cycle_start,
  output logic page_req,
  output logic [7:0] prog_idx,
  output logic [7:0] page_idx,
  input wire logic page_done,
  input wire logic page_last,
  input wire logic prog_last,
  // event log read port
  input wire logic [`LFS_LOG_AW-1:0] log_raddr,
  output logic [`LFS_CODE_W+`LFS_STAMP_W:0] log_rdata,
  output logic [`LFS_LOG_AW-1:0] log_count
);
  import lfs_pkg::*;
  localparam int NF = FW + `LFS_FLT_BASE;
  localparam int LW = `LFS_CODE_W + `LFS_STAMP_W + 1;

  // index of the lowest set bit, zero when none
  function automatic logic [`LFS_CODE_W-1:0] first_set(
    input logic [31:0] v);
    logic [`LFS_CODE_W-1:0] r;
    r = '0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) r = `LFS_CODE_W'(i);
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // time base
  logic [31:0] cyc_cnt, sec_cnt, hb_cnt;
  logic [`LFS_STAMP_W-1:0] seconds;
  wire cyc_tick = cyc_cnt == 32'(CYCLE_TICKS - 1);
  wire sec_tick = sec_cnt == 32'(SEC_TICKS - 1);
  wire hb_tick = hb_cnt == 32'(HB_TICKS - 1);

  // free-running dividers, one-cycle enables
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_cnt <= '0;
      sec_cnt <= '0;
      hb_cnt <= '0;
      seconds <= '0;
    end else begin
      cyc_cnt <= cyc_tick ? '0 : cyc_cnt + 32'h1;
      sec_cnt <= sec_tick ? '0 : sec_cnt + 32'h1;
      hb_cnt <= hb_tick ? '0 : hb_cnt + 32'h1;
      if (sec_tick) seconds <= seconds + `LFS_STAMP_W'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // heartbeat broadcast and continuity check
  logic time_due, ret_wait, hb_fail;
  logic [31:0] ret_cnt;
  wire ret_seen = hb_rx_b | hb_rx_a;
  wire ret_miss = ret_wait && !ret_seen && ret_cnt == 32'(RET_TICKS - 1);

  // both directions every period; time rides the first beat after each second tick, not one sent in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      hb_send_a <= 1'b0;
      hb_send_b <= 1'b0;
      hb_with_time <= 1'b0;
      time_due <= 1'b1;
    end else begin
      hb_send_a <= hb_tick;
      hb_send_b <= hb_tick;
      hb_with_time <= hb_tick && time_due;
      if (sec_tick) time_due <= 1'b1;
      else if (hb_tick) time_due <= 1'b0;
    end
  end

  // a beat sent on both ports must come back on either port in time
  always_ff @(posedge clk) begin
    if (rst) begin
      ret_wait <= 1'b0;
      ret_cnt <= '0;
      hb_fail <= 1'b0;
    end else begin
      if (hb_send_a) begin
        ret_wait <= 1'b1;
        ret_cnt <= '0;
      end else if (ret_wait && ret_seen) begin
        ret_wait <= 1'b0;
      end else if (ret_miss) begin
        ret_wait <= 1'b0;
      end else if (ret_wait) begin
        ret_cnt <= ret_cnt + 32'h1;
      end
      if (ret_miss) hb_fail <= 1'b1;
      else if (ret_wait && ret_seen) hb_fail <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // condition latches
  logic [NF-1:0] flt_lat;
  logic [NA-1:0] alm_lat;
  wire [NF-1:0] flt_act = {field_fault, dev_offline, hb_fail, ctrl_fault};
  wire [NA-1:0] alm_act_q = alarm_in;
  wire all_quiet = !(|flt_act) && !(|alm_act_q);
  wire clr_ok = reset_btn && all_quiet;
  wire [NF-1:0] flt_new = flt_act & ~flt_lat;
  wire [NA-1:0] alm_new = alm_act_q & ~alm_lat;

  // setting beats clearing, so a live alarm outlives a reset
  always_ff @(posedge clk) begin
    if (rst) begin
      flt_lat <= '0;
      alm_lat <= '0;
    end else begin
      flt_lat <= (clr_ok ? '0 : flt_lat) | flt_act;
      alm_lat <= (clr_ok ? '0 : alm_lat) | alm_act_q;
    end
  end

  // annunciation follows the latches; alarm tone outranks trouble
  wire any_flt = |flt_lat;
  wire any_alm = |alm_lat;
  assign trouble_led = any_flt;
  assign loop_fault_led = flt_lat[`LFS_FLT_LOOP];
  assign trouble_relay = !any_flt;
  assign alarm_led = any_alm;
  assign tone = any_alm ? tone_alarm : (any_flt ? tone_trouble : tone_off);
  assign disp_alarm = any_alm;
  assign disp_offline = flt_lat[`LFS_FLT_OFFL];
  assign disp_code = any_alm ? first_set(32'(alm_lat))
                             : first_set(32'(flt_lat));

  //////////////////////////////////////////////////////////////////////////
  // event log, a ring that keeps the newest entries
  logic [`LFS_LOG_AW-1:0] log_wptr;
  wire log_we = |flt_new || |alm_new;
  wire [LW-1:0] log_entry = |alm_new
    ? {1'b1, first_set(32'(alm_new)), seconds}
    : {1'b0, first_set(32'(flt_new)), seconds};
  wire wrap = log_wptr == `LFS_LOG_AW'(`LFS_LOG_DEPTH - 1);

  // only one of several same-cycle events gets an entry: the lowest new alarm, else the lowest new fault
  always_ff @(posedge clk) begin
    if (rst) begin
      log_wptr <= '0;
      log_count <= '0;
    end else if (log_we) begin
      log_wptr <= wrap ? '0 : log_wptr + `LFS_LOG_AW'h1;
      if (log_count != `LFS_LOG_AW'(`LFS_LOG_DEPTH))
        log_count <= log_count + `LFS_LOG_AW'h1;
    end
  end

  lfs_log_mem #(.W(LW), .D(1 << `LFS_LOG_AW), .AW(`LFS_LOG_AW)) u_log (
    .clk(clk),
    .we(log_we),
    .waddr(log_wptr),
    .wdata(log_entry),
    .raddr(log_raddr),
    .rdata(log_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // user logic scheduler
  lfs_sched_e sched;
  assign cycle_start = cyc_tick;
  assign page_req = sched == sch_run;
  wire step = page_req && page_done;

  // pages run back to back; an unfinished pass carries over the tick
  always_ff @(posedge clk) begin
    if (rst) begin
      sched <= sch_wait;
      prog_idx <= '0;
      page_idx <= '0;
    end else begin
      case (sched)
        sch_wait: begin
          if (cyc_tick) begin
            sched <= sch_run;
            prog_idx <= '0;
            page_idx <= '0;
          end
        end
        sch_run: begin
          if (step && page_last && prog_last) begin
            sched <= sch_wait;
          end else if (step && page_last) begin
            prog_idx <= prog_idx + 8'h1;
            page_idx <= '0;
          end else if (step) begin
            page_idx <= page_idx + 8'h1;
          end
        end
        default: sched <= sch_wait;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_trouble_relay: assert property (@(posedge clk) disable iff (rst)
    (|flt_act) |=> !trouble_relay && trouble_led && tone != tone_off)
    else $error("fault did not drop the trouble relay");
  a_alarm_tone: assert property (@(posedge clk) disable iff (rst)
    (|alarm_in) |=> tone == tone_alarm && alarm_led && disp_alarm)
    else $error("alarm not annunciated");
  a_loop_fault: assert property (@(posedge clk) disable iff (rst)
    ret_miss |=> ##1 trouble_led && loop_fault_led)
    else $error("lost heartbeat not raised as fault");
  a_reset_blocked: assert property (@(posedge clk) disable iff (rst)
    reset_btn && (|flt_act) |=> any_flt)
    else $error("reset cleared with an active fault");
  a_alarm_survives: assert property (@(posedge clk) disable iff (rst)
    reset_btn && (|alarm_in) |=> alarm_led)
    else $error("active alarm lost at reset");
  a_fault_held: assert property (@(posedge clk) disable iff (rst)
    any_flt && !reset_btn |=> any_flt)
    else $error("fault latch dropped without reset");
  a_log_count: assert property (@(posedge clk) disable iff (rst)
    log_we && log_count < `LFS_LOG_AW'(`LFS_LOG_DEPTH)
      |=> log_count == $past(log_count) + `LFS_LOG_AW'h1)
    else $error("log count did not advance");
  a_hb_both: assert property (@(posedge clk) disable iff (rst)
    hb_tick |=> hb_send_a && hb_send_b)
    else $error("heartbeat not sent both ways");
  a_restart_first: assert property (@(posedge clk) disable iff (rst)
    cyc_tick && sched == sch_wait |=> page_req && prog_idx == 8'h0
      && page_idx == 8'h0)
    else $error("cycle did not restart at first page");
  a_resume_pass: assert property (@(posedge clk) disable iff (rst)
    cyc_tick && sched == sch_run && !page_done
      |=> page_req && $stable(prog_idx) && $stable(page_idx))
    else $error("unfinished pass was restarted");
  a_offline_shown: assert property (@(posedge clk) disable iff (rst)
    dev_offline |=> disp_offline)
    else $error("device offline not shown");
  c_reset_ok: cover property (@(posedge clk) disable iff (rst)
    any_flt && clr_ok ##1 !any_flt);
  c_prog_wrap: cover property (@(posedge clk) disable iff (rst)
    step && page_last && !prog_last);
  c_hb_lost: cover property (@(posedge clk) disable iff (rst) ret_miss);
  c_time_beat: cover property (@(posedge clk) disable iff (rst)
    hb_with_time);
endmodule // lfs_supervisor

// file: logic/lfs_consts.svh
// constants of the loop fault supervisor
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
`define LFS_CLK_MHZ 100
`define LFS_CYCLE_MS 100
`define LFS_SEC_MS 1000
`define LFS_HB_MS 10
`define LFS_RET_MS 5
`define LFS_MS2CYC(ms) ((ms) * 1000 * `LFS_CLK_MHZ)
`define LFS_LOG_DEPTH 4095
`define LFS_LOG_AW 12
`define LFS_CODE_W 8
`define LFS_STAMP_W 16
`define LFS_FLT_CTRL 0
`define LFS_FLT_LOOP 1
`define LFS_FLT_OFFL 2
`define LFS_FLT_BASE 3
`endif

// file: logic/lfs_pkg.sv
// types of the loop fault supervisor
package lfs_pkg;
  typedef enum logic [1:0] {tone_off, tone_trouble, tone_alarm} lfs_tone_e;
  typedef enum logic {sch_wait, sch_run} lfs_sched_e;
endpackage

// file: logic/lfs_log_mem.sv
// event log memory with registered read data
module lfs_log_mem #(
  parameter int W = 25,
  parameter int D = 4096,
  parameter int AW = 12
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read side
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [D];

  // one write and one registered read per cycle
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // lfs_log_mem

// file: test/lfs_loop_model.sv
// loop and logic engine model facing the supervisor
module lfs_loop_model #(
  parameter int PAGES = 4,
  parameter int PROGS = 3,
  // heartbeat silence before isolating, and dwell per port
  parameter int LOSS = 120,
  parameter int DWELL = 40,
  // isolation limit, scaled down from hours for simulation
  parameter int ISO_MAX = 300,
  parameter int RPT = 500
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench controls
  input wire logic hb_ret,
  input wire logic [7:0] page_lat,
  // heartbeat leaving and returning
  input wire logic hb_send_a,
  input wire logic hb_send_b,
  output logic hb_rx_a,
  output logic hb_rx_b,
  // page engine
  input wire logic page_req,
  input wire logic [7:0] prog_idx,
  input wire logic [7:0] page_idx,
  output logic page_done,
  output logic page_last,
  output logic prog_last,
  // field device relays, high = closed, and status reports
  output logic relay_a,
  output logic relay_b,
  output logic iso_on,
  output logic dev_rpt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] via_a;
  logic [2:0] via_b;
  logic [7:0] cnt;
  logic junk;
  logic [15:0] quiet, dwell, iso_t, rpt_t;
  logic iso_off;
  wire heard = (hb_send_a | hb_send_b) & hb_ret;
  wire fin = page_req & (cnt >= page_lat);
  //////////////////////////////////////////////////////////////////////
  // a beat sent on one port comes back on the other after 3 cycles
  always_ff @(posedge clk) begin
    via_a <= rst ? 3'h0 : {via_a[1:0], hb_send_a & hb_ret};
    via_b <= rst ? 3'h0 : {via_b[1:0], hb_send_b & hb_ret};
  end
  assign hb_rx_b = via_a[2];
  assign hb_rx_a = via_b[2];
  //////////////////////////////////////////////////////////////////////
  // latency of at least one keeps done from seeing a stale index;
  // qualifiers toggle when done is low, never hold a stale value
  always_ff @(posedge clk) begin
    junk <= rst ? 1'b0 : ~junk;
    cnt <= (rst | fin | ~page_req) ? 8'h0 : cnt + 8'h1;
    page_done <= ~rst & fin;
    page_last <= fin ? (page_idx == 8'(PAGES - 1)) : junk;
    prog_last <= fin ? (prog_idx == 8'(PROGS - 1)) : ~junk;
  end
  //////////////////////////////////////////////////////////////////////
  // field device: a silent loop opens one port, ports swap each dwell;
  // a heard beat or the isolation limit closes both relays again
  always_ff @(posedge clk) begin
    if (rst | heard) begin
      quiet <= 16'h0;
      dwell <= 16'h0;
      iso_t <= 16'h0;
      {relay_a, relay_b, iso_on, iso_off} <= 4'hC;
    end else if (iso_on && iso_t == 16'(ISO_MAX - 1)) begin
      {relay_a, relay_b, iso_on, iso_off} <= 4'hD;
    end else if (iso_on) begin
      iso_t <= iso_t + 16'h1;
      dwell <= (dwell == 16'(DWELL - 1)) ? 16'h0 : dwell + 16'h1;
      if (dwell == 16'(DWELL - 1)) begin
        {relay_a, relay_b} <= {relay_b, relay_a};
      end
    end else if (!iso_off && quiet == 16'(LOSS - 1)) begin
      {relay_a, relay_b, iso_on} <= 3'h3;
    end else if (!iso_off) begin
      quiet <= quiet + 16'h1;
    end
  end
  // status report at the slowest interval a device may use
  always_ff @(posedge clk) begin
    rpt_t <= (rst || rpt_t == 16'(RPT - 1)) ? 16'h0 : rpt_t + 16'h1;
    dev_rpt <= !rst && rpt_t == 16'(RPT - 1);
  end
endmodule // lfs_loop_model

// file: test/testbench.sv
// self-checking bench of the loop fault supervisor
module testbench;
  import lfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 200, SEC = 500, HB = 50, RET = 20;
  localparam int LOSS = 120, ISO = 300;
  logic relay_a, relay_b, iso_on, dev_rpt;
  logic clk, rst, ctrl_fault, dev_offline, reset_btn, hb_ret;
  logic [3:0] field_fault, alarm_in;
  logic hb_send_a, hb_send_b, hb_with_time, hb_rx_a, hb_rx_b;
  logic trouble_led, loop_fault_led, alarm_led, trouble_relay;
  logic disp_alarm, disp_offline, cycle_start, page_req;
  logic page_done, page_last, prog_last;
  lfs_tone_e tone;
  logic [7:0] disp_code, prog_idx, page_idx, page_lat, ep, eg;
  logic [11:0] log_raddr, log_count;
  logic [24:0] log_rdata;
  logic [31:0] seed;
  int bad_count, num_checks, rounds, timed;
  time last_cs, last_rpt;
  lfs_supervisor #(.FW(4), .NA(4), .CYCLE_TICKS(CYC), .SEC_TICKS(SEC),
    .HB_TICKS(HB), .RET_TICKS(RET)) dut (.clk, .rst, .ctrl_fault,
    .dev_offline, .field_fault, .alarm_in, .reset_btn, .trouble_led,
    .loop_fault_led, .alarm_led, .trouble_relay, .tone, .disp_alarm,
    .disp_code, .disp_offline, .hb_send_a, .hb_send_b, .hb_with_time,
    .hb_rx_a, .hb_rx_b, .cycle_start, .page_req, .prog_idx, .page_idx,
    .page_done, .page_last, .prog_last, .log_raddr, .log_rdata,
    .log_count);
  lfs_loop_model #(.LOSS(LOSS), .ISO_MAX(ISO), .RPT(SEC)) far (.clk, .rst,
    .hb_ret, .page_lat, .hb_send_a, .hb_send_b, .hb_rx_a, .hb_rx_b,
    .page_req, .prog_idx, .page_idx, .page_done, .page_last, .prog_last,
    .relay_a, .relay_b, .iso_on, .dev_rpt);
  //////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // next random word
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic press();
    reset_btn = 1'b1;
    tick(1);
    reset_btn = 1'b0;
    tick(1);
  endtask
  task automatic finish_test();
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // one fault or alarm raised, refused reset, recovery, accepted reset
  task automatic event_case(input logic [1:0] k, input logic [1:0] i);
    logic [11:0] cnt0;
    logic [7:0] ec;
    cnt0 = log_count;
    log_raddr = cnt0;
    ec = (k == 0) ? 8'(i) + 8'h3 : (k == 1) ? 8'h0 : (k == 2) ? 8'h2 : 8'(i);
    case (k)
      2'd0: field_fault[i] = 1'b1;
      2'd1: ctrl_fault = 1'b1;
      2'd2: dev_offline = 1'b1;
      default: alarm_in[i] = 1'b1;
    endcase
    tick(1);
    chk({alarm_led, disp_alarm, trouble_led, trouble_relay, disp_offline},
      (k == 3) ? 5'h1A : (k == 2) ? 5'h05 : 5'h04);
    chk(disp_code, ec);
    chk(32'(tone), (k == 3) ? 32'(tone_alarm) : 32'(tone_trouble));
    chk(log_count, cnt0 + 12'h1);
    press();
    chk(alarm_led | trouble_led, 1);
    chk(log_rdata[24:16], {k == 3, ec});
    {field_fault, alarm_in, ctrl_fault, dev_offline} = 10'h000;
    tick(3);
    chk(alarm_led | trouble_led, 1);
    press();
    chk({alarm_led, trouble_led, trouble_relay, disp_offline}, 4'h2);
  endtask
  //////////////////////////////////////////////////////////////////////
  // watches beats, cycle spacing and page order across cycles
  always @(posedge clk) begin
    if (rst) begin
      ep = 8'h0;
      eg = 8'h0;
    end else begin
      if (hb_send_a | hb_send_b) chk(hb_send_b, hb_send_a);
      if (hb_with_time) timed++;
      if (hb_with_time) chk(hb_send_a, 1);
      if (dev_rpt) begin
        if (last_rpt > 0) chk(32'($time - last_rpt <= SEC * 10), 1);
        last_rpt = $time;
      end
      if (cycle_start) begin
        if (last_cs > 0) chk(32'($time - last_cs), CYC * 10);
        last_cs = $time;
      end
      if (page_done && page_req) begin
        chk({prog_idx, page_idx}, {ep, eg});
        if (prog_last && page_last) begin
          ep = 8'h0;
          eg = 8'h0;
          rounds++;
        end else if (page_last) begin
          ep++;
          eg = 8'h0;
        end else eg++;
      end
    end
  end
  // watchdog, far above the expected run length
  initial begin
    #200000;
    bad_count++;
    $display("BAD t=%0t watchdog", $time);
    finish_test();
  end
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'hFEB7F611;
    {bad_count, num_checks, rounds, timed} = '0;
    last_cs = 0;
    last_rpt = 0;
    {rst, hb_ret} = 2'b11;
    {ctrl_fault, dev_offline, reset_btn} = 3'b000;
    {field_fault, alarm_in} = 8'h00;
    page_lat = 8'h3;
    log_raddr = 12'h000;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    tick(1);
    chk({trouble_relay, trouble_led, alarm_led, log_count}, 15'h4000);
    chk(32'(tone), 32'(tone_off));
    event_case(2'd1, 2'd0);
    event_case(2'd2, 2'd3);
    for (int n = 0; n < 10; n++) begin
      seed = lfsr(seed);
      page_lat = 8'(seed[4:0]) + 8'h1;
      log_raddr = seed[27:16];
      event_case(seed[7:6], seed[9:8]);
    end
    // loop stops returning the beat
    hb_ret = 1'b0;
    for (int w = 0; w < HB + RET + 8 && loop_fault_led !== 1'b1; w++) tick(1);
    chk({loop_fault_led, trouble_led, trouble_relay}, 3'h6);
    // far side isolates, then gives up after its limit
    tick(LOSS + 30);
    chk({iso_on, relay_a ^ relay_b}, 2'h3);
    tick(ISO);
    chk({iso_on, relay_a, relay_b}, 3'h3);
    hb_ret = 1'b1;
    tick(2 * HB);
    press();
    chk(loop_fault_led, 0);
    tick(5 * CYC);
    chk(32'(rounds > 1), 1);
    chk(32'(timed > 0), 1);
    finish_test();
  end
endmodule // testbench
